// File: hdl/vtrc_map.svh
// register map, field positions, reset values and encodings of the transmit retry and mode control
// assumes inclusion by bare name from the package and the core
`ifndef VTRC_MAP_SVH
`define VTRC_MAP_SVH
// =====================================================================
// global register offsets
`define VTRC_TX_CONTROL_ADDR 8'h01
`define VTRC_COMMAND_ADDR 8'h03
`define VTRC_LINE_STATE_ADDR 8'h04
`define VTRC_PROGRESS_ADDR 8'h05
`define VTRC_FAILURE_ADDR 8'h07
`define VTRC_IRQ_FLAGS_ADDR 8'h09
// =====================================================================
// channel register sets: base 0x40, four bytes per channel
`define VTRC_CH_WINDOW 2'h1
`define VTRC_CH_PTR_OFS 2'h2
`define VTRC_CH_LEN_OFS 2'h3
`define VTRC_NUM_CH 14
// =====================================================================
// command register fields
`define VTRC_CMD_BUS_ENABLE_BIT_BIT 0
`define VTRC_CMD_IDLE_BIT 1
`define VTRC_CMD_SLEEP_BIT 2
`define VTRC_CMD_REARB_BIT 3
`define VTRC_CMD_RESET 8'h02
// length and state fields: [7:3] length, 2 abort, 1 transmitted, 0 received
`define VTRC_LEN_ABORT_BIT 2
`define VTRC_LEN_TX_BIT 1
`define VTRC_LEN_RX_BIT 0
`define VTRC_CH_LEN_RESET 8'h03
`define VTRC_CH_PTR_RESET 8'h00
`define VTRC_TX_CONTROL_RESET 8'h00
// failure cause fields
`define VTRC_FAIL_CV_BIT 0
`define VTRC_FAIL_ACKNOWLEDGE_FAULT_FLAG_BIT 1
`define VTRC_FAIL_FRAME_CHECK_FAULT_FLAG_BIT 2
// interrupt flag field
`define VTRC_IRQ_TE_BIT 0
`endif

// File: hdl/vtrc_pkg.sv
// types shared by the transmit retry and mode control
// assumes the map header is on the include path
`include "vtrc_map.svh"
package vtrc_pkg;
	// =====================================================================
	// frame engine request and attempt outcome
	typedef struct packed {
		logic [3:0] chan; // channel that owns the attempt
		logic [6:0] ptr; // message area pointer, after linking
		logic [4:0] len; // message length, after linking
	} vtrc_req_s;
	typedef struct packed {
		logic contention; // lost arbitration, not a failure
		logic code_viol; // coding violation seen
		logic ack_fault; // no acknowledge
		logic crc_fault; // frame check failed
	} vtrc_result_s;
	typedef enum logic [1:0] {ST_PICK, ST_LAUNCH, ST_WAIT} vtrc_state_e;
	typedef enum logic [1:0] {PH_NONE, PH_DETOUR, PH_RESUME} vtrc_phase_e;
endpackage

// File: hdl/vtrc_core.sv
// transmit retry, rearbitrate, abort, operating mode and channel linking control
// assumes a serial host front end and a frame engine, both on ref_clk
`timescale 1ns/10ps
`include "vtrc_map.svh"
// Overview of operation
// RULE_01: load retry counter when channel transmission starts
// RULE_02: count failures; exhausted sets error flag, stops
// RULE_03: value N gives N plus one attempts
// RULE_04: progress register shows retries and channel
// RULE_05: record failure cause: violation, acknowledge, crc
// RULE_06: contention never decrements the retry counter
// RULE_07: one shared counter, latest maximum used
// RULE_08: retry, rearbitrate, abort only for producer channels
// RULE_09: rearbitrate lets higher channel go, then resumes
// RULE_10: idle entered only after pending attempts end
// RULE_11: disabled postponed channel passes to next valid
// RULE_12: host aborts by setting channel abort bit
// RULE_13: abort only untransmitted; completion sets transmitted flag
// RULE_14: reset leaves idle, clock running, transmit tri-stated
// RULE_15: host activates: set enable, clear idle
// RULE_16: line state shows current idle state
// RULE_17: sleep overrides, stops clock and host access
// RULE_18: sleep left only through reset
// RULE_19: zero length marks channel linked via pointer
// RULE_20: linked channel uses target pointer and length
// RULE_21: host links only one level deep
// RULE_22: linked channels keep other settings independent
// RULE_23: lowest ready channel number wins priority
module vtrc_core
	import vtrc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reg_wr, // host write strobe, one cycle
	input wire logic reg_rd, // host read strobe, one cycle
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata, // valid the cycle after reg_rd
	input wire logic [13:0] chan_producer, // channel acts as frame producer
	output logic tx_start, // one-cycle attempt launch pulse
	output vtrc_req_s tx_req, // held while attempt runs
	input wire logic att_done, // one-cycle end of attempt
	input wire vtrc_result_s att_result, // outcome with att_done
	output logic txd_oe_n, // bus transmit drive, low while driven
	output logic osc_run, // oscillator running
	output logic buffered_clock_output // clock output enable
);
	// =====================================================================
	// register storage
	logic [3:0] max_retry_field_reg; // maximum retry value
	logic [7:0] cmd_reg; // activate, idle, sleep; the rearbitrate bit is not stored
	logic [2:0] fail_reg; // last failure cause
	logic te_reg; // transmit failure event flag
	logic [3:0] retry_cnt_reg; // shared retry down-counter
	logic [3:0] retries_done_reg; // retries performed so far
	logic [6:0] ptr_reg [0:13]; // message pointers
	logic [4:0] len_reg [0:13]; // message lengths
	logic [13:0] channel_abort_error_bit;
	logic [13:0] channel_transmitted_flag;
	logic [13:0] channel_received_flag;
	logic idle_mode_reg; // device idle
	logic sleep_reg; // device asleep
	vtrc_state_e state_reg;
	vtrc_phase_e phase_reg;
	logic [3:0] cur_ch_reg; // channel in transmission
	logic [3:0] post_ch_reg; // postponed channel
	logic rearb_pend_reg; // rearbitrate requested
	logic [13:0] abort_vec; // abort completing on an idle channel, per channel

	// =====================================================================
	// host decode; nothing reaches the registers while asleep
	logic wr_ok;
	logic rd_ok;
	logic ch_hit;
	logic [3:0] ch_idx;
	assign wr_ok = reg_wr && !sleep_reg; // RULE_17
	assign rd_ok = reg_rd && !sleep_reg; // RULE_17
	assign ch_idx = reg_addr[5:2];
	assign ch_hit = (reg_addr[7:6] == `VTRC_CH_WINDOW) && (ch_idx < 4'(`VTRC_NUM_CH));

	// =====================================================================
	// attempt end classification
	logic failed; // counted failure
	logic exhausted; // counted failure with no retries left
	logic cur_done; // current channel ends, successfully or not
	logic cur_abort; // current channel aborted at this attempt end
	logic retry_same; // current channel launches again
	assign failed = att_done && !att_result.contention
		&& (att_result.code_viol || att_result.ack_fault || att_result.crc_fault); // RULE_06
	assign exhausted = failed && (retry_cnt_reg == 4'h0); // RULE_03
	assign cur_abort = att_done && channel_abort_error_bit[cur_ch_reg];
	assign cur_done = att_done && (!failed && !att_result.contention || exhausted || cur_abort);
	assign retry_same = att_done && !cur_done;

	// =====================================================================
	// readiness and lowest-number pick, optionally skipping the postponed channel
	logic [13:0] ready;
	logic [3:0] pick_ch;
	logic pick_ok;
	assign ready = chan_producer & ~channel_transmitted_flag & ~channel_abort_error_bit; // RULE_08
	always_comb begin
		pick_ok = 1'b0;
		pick_ch = 4'h0;
		for (int i = `VTRC_NUM_CH - 1; i >= 0; i--) begin
			if (ready[i] && !(phase_reg == PH_DETOUR && post_ch_reg == 4'(i))) begin
				pick_ok = 1'b1; // RULE_23
				pick_ch = 4'(i);
			end
		end
	end
	logic go; // a channel is launched from the pick state
	logic [3:0] go_ch;
	always_comb begin
		go = 1'b0;
		go_ch = pick_ch;
		if (state_reg == ST_PICK && !idle_mode_reg) begin
			if (phase_reg == PH_RESUME && ready[post_ch_reg]) begin
				go = 1'b1; // RULE_09
				go_ch = post_ch_reg;
			end else begin
				go = pick_ok; // RULE_11
			end
		end
	end

	// =====================================================================
	// linked channel resolution: zero length borrows the target's area
	logic [3:0] link_ch;
	assign link_ch = (len_reg[go_ch] == 5'h00) ? ptr_reg[go_ch][3:0] : go_ch; // RULE_19

	// =====================================================================
	// transmit sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_PICK;
			cur_ch_reg <= 4'h0;
			tx_req <= '0;
			tx_start <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			case (state_reg)
				ST_PICK: begin
					if (go) begin
						cur_ch_reg <= go_ch;
						tx_req.chan <= go_ch; // RULE_22
						tx_req.ptr <= ptr_reg[link_ch]; // RULE_20
						tx_req.len <= len_reg[link_ch]; // RULE_20
						state_reg <= ST_LAUNCH;
					end
				end
				ST_LAUNCH: begin
					tx_start <= 1'b1;
					state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (att_done) begin
						if (retry_same && !(rearb_pend_reg && phase_reg == PH_NONE)) begin
							state_reg <= ST_LAUNCH;
						end else begin
							state_reg <= ST_PICK; // RULE_09
						end
					end
				end
				default: state_reg <= ST_PICK;
			endcase
		end
	end

	// =====================================================================
	// rearbitrate bookkeeping
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= PH_NONE;
			post_ch_reg <= 4'h0;
			rearb_pend_reg <= 1'b0;
		end else begin
			if (wr_ok && reg_addr == `VTRC_COMMAND_ADDR && reg_wdata[`VTRC_CMD_REARB_BIT]
				&& state_reg != ST_PICK && chan_producer[cur_ch_reg]) begin
				rearb_pend_reg <= 1'b1; // RULE_08
			end else if (att_done || state_reg == ST_PICK) begin
				rearb_pend_reg <= 1'b0;
			end
			if (state_reg == ST_WAIT && retry_same && rearb_pend_reg && phase_reg == PH_NONE) begin
				post_ch_reg <= cur_ch_reg; // RULE_09
				phase_reg <= PH_DETOUR;
			end else if (state_reg == ST_PICK && phase_reg == PH_DETOUR && !go && !idle_mode_reg) begin
				phase_reg <= PH_RESUME;
			end else if (state_reg == ST_WAIT && cur_done && phase_reg == PH_DETOUR) begin
				phase_reg <= PH_RESUME;
			end else if (state_reg == ST_PICK && phase_reg == PH_RESUME && !idle_mode_reg) begin
				phase_reg <= PH_NONE; // RULE_11
			end
		end
	end

	// =====================================================================
	// shared retry counter and retries performed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			retry_cnt_reg <= 4'h0;
			retries_done_reg <= 4'h0;
		end else if (go) begin
			retry_cnt_reg <= max_retry_field_reg; // RULE_01 RULE_07
			retries_done_reg <= 4'h0;
		end else if (state_reg == ST_WAIT && failed && !exhausted) begin
			retry_cnt_reg <= retry_cnt_reg - 4'h1; // RULE_02
			retries_done_reg <= retries_done_reg + 4'h1; // RULE_04
		end
	end

	// =====================================================================
	// failure cause and transmit failure event, hardware set wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fail_reg <= 3'h0;
		end else if (failed) begin
			fail_reg <= {att_result.crc_fault, att_result.ack_fault, att_result.code_viol}; // RULE_05
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			te_reg <= 1'b0;
		end else if (state_reg == ST_WAIT && exhausted) begin
			te_reg <= 1'b1; // RULE_02
		end else if (wr_ok && reg_addr == `VTRC_IRQ_FLAGS_ADDR && reg_wdata[`VTRC_IRQ_TE_BIT]) begin
			te_reg <= 1'b0;
		end
	end

	// =====================================================================
	// global host registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			max_retry_field_reg <= 4'(`VTRC_TX_CONTROL_RESET);
			cmd_reg <= `VTRC_CMD_RESET;
			sleep_reg <= 1'b0;
		end else begin
			if (wr_ok && reg_addr == `VTRC_TX_CONTROL_ADDR) begin
				max_retry_field_reg <= reg_wdata[3:0]; // RULE_07
			end
			if (wr_ok && reg_addr == `VTRC_COMMAND_ADDR) begin
				cmd_reg <= {5'h00, reg_wdata[2:0]}; // RULE_15
				if (reg_wdata[`VTRC_CMD_SLEEP_BIT]) begin
					sleep_reg <= 1'b1; // RULE_17 RULE_18
				end
			end
		end
	end

	// =====================================================================
	// idle mode follows the command only between attempts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle_mode_reg <= 1'b1; // RULE_14
		end else if (!cmd_reg[`VTRC_CMD_BUS_ENABLE_BIT_BIT] || cmd_reg[`VTRC_CMD_IDLE_BIT] || sleep_reg) begin
			if (state_reg == ST_PICK && !go && phase_reg == PH_NONE) begin
				idle_mode_reg <= 1'b1; // RULE_10
			end
		end else begin
			idle_mode_reg <= 1'b0; // RULE_15
		end
	end
	// sleep stops driving at once, without waiting for the attempt to end
	assign txd_oe_n = idle_mode_reg || sleep_reg; // RULE_14 RULE_17
	assign osc_run = !sleep_reg; // RULE_17
	assign buffered_clock_output = !sleep_reg; // RULE_14 RULE_17

	// =====================================================================
	// per-channel register sets
	for (genvar c = 0; c < `VTRC_NUM_CH; c++) begin : g_ch
		logic wr_ptr;
		logic wr_len;
		logic abort_now; // abort completes on an idle channel
		logic end_here; // this channel's transmission ends now
		assign wr_ptr = wr_ok && ch_hit && ch_idx == 4'(c) && reg_addr[1:0] == `VTRC_CH_PTR_OFS;
		assign wr_len = wr_ok && ch_hit && ch_idx == 4'(c) && reg_addr[1:0] == `VTRC_CH_LEN_OFS;
		assign abort_now = channel_abort_error_bit[c] && chan_producer[c] && !channel_transmitted_flag[c]
			&& !(state_reg != ST_PICK && cur_ch_reg == 4'(c)); // RULE_13
		assign end_here = state_reg == ST_WAIT && cur_done && cur_ch_reg == 4'(c);
		assign abort_vec[c] = abort_now; // RULE_13
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				ptr_reg[c] <= 7'(`VTRC_CH_PTR_RESET);
			end else if (wr_ptr) begin
				ptr_reg[c] <= reg_wdata[6:0]; // RULE_19
			end
		end
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				len_reg[c] <= 5'(`VTRC_CH_LEN_RESET >> 3);
				channel_abort_error_bit[c] <= 1'b0;
				channel_transmitted_flag[c] <= 1'b1;
				channel_received_flag[c] <= 1'b1;
			end else begin
				if (wr_len) begin
					len_reg[c] <= reg_wdata[7:3];
					channel_abort_error_bit[c] <= reg_wdata[`VTRC_LEN_ABORT_BIT]; // RULE_12
					channel_received_flag[c] <= reg_wdata[`VTRC_LEN_RX_BIT];
				end
				if (end_here || abort_now) begin
					channel_transmitted_flag[c] <= 1'b1; // RULE_02 RULE_13
				end else if (wr_len) begin
					channel_transmitted_flag[c] <= reg_wdata[`VTRC_LEN_TX_BIT];
				end
			end
		end
	end

	// =====================================================================
	// host read data
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (rd_ok) begin
			reg_rdata <= 8'h00;
			if (ch_hit && reg_addr[1:0] == `VTRC_CH_PTR_OFS) begin
				reg_rdata <= {1'b0, ptr_reg[ch_idx]};
			end else if (ch_hit && reg_addr[1:0] == `VTRC_CH_LEN_OFS) begin
				reg_rdata <= {len_reg[ch_idx], channel_abort_error_bit[ch_idx],
					channel_transmitted_flag[ch_idx], channel_received_flag[ch_idx]};
			end else begin
				case (reg_addr)
					`VTRC_TX_CONTROL_ADDR: reg_rdata <= {4'h0, max_retry_field_reg};
					`VTRC_COMMAND_ADDR: reg_rdata <= cmd_reg;
					`VTRC_LINE_STATE_ADDR: reg_rdata <= {7'h00, idle_mode_reg}; // RULE_16
					`VTRC_PROGRESS_ADDR: reg_rdata <= {retries_done_reg, cur_ch_reg}; // RULE_04
					`VTRC_FAILURE_ADDR: reg_rdata <= {5'h00, fail_reg};
					`VTRC_IRQ_FLAGS_ADDR: reg_rdata <= {7'h00, te_reg};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_retry_load: assert property (go |=> retry_cnt_reg == $past(max_retry_field_reg)) // RULE_01
		else $error("retry counter not loaded on launch");
	a_exhaust_flag: assert property (state_reg == ST_WAIT && exhausted |=> te_reg) // RULE_02
		else $error("exhausted count did not flag failure");
	a_fail_count: assert property (state_reg == ST_WAIT && failed && !exhausted
		|=> retry_cnt_reg == $past(retry_cnt_reg) - 4'h1 && retries_done_reg == $past(retries_done_reg) + 4'h1) // RULE_03
		else $error("failure did not count down once");
	a_contention_free: assert property (att_done && att_result.contention && !failed
		|=> $stable(retry_cnt_reg)) // RULE_06
		else $error("contention changed the retry counter");
	a_cause_kept: assert property (failed |=> fail_reg[`VTRC_FAIL_ACKNOWLEDGE_FAULT_FLAG_BIT] == $past(att_result.ack_fault)) // RULE_05
		else $error("acknowledge cause not recorded");
	sequence s_rearb_taken;
		state_reg == ST_WAIT && retry_same && rearb_pend_reg && phase_reg == PH_NONE;
	endsequence
	a_rearb_park: assert property (s_rearb_taken |=> phase_reg == PH_DETOUR
		&& post_ch_reg == $past(cur_ch_reg) && state_reg == ST_PICK) // RULE_09
		else $error("rearbitrate did not park the channel");
	a_idle_wait: assert property ($rose(idle_mode_reg) |-> $past(state_reg) == ST_PICK) // RULE_10
		else $error("idle entered during an attempt");
	a_sleep_stop: assert property (sleep_reg |-> !osc_run && !buffered_clock_output && txd_oe_n ##1 sleep_reg) // RULE_17
		else $error("sleep not holding clock stopped");
	a_abort_done: assert property (|abort_vec |=> (channel_transmitted_flag & $past(abort_vec)) == $past(abort_vec)) // RULE_13
		else $error("abort did not set transmitted flag");
	a_idle_tristate: assert property (idle_mode_reg |-> txd_oe_n && !tx_start ##1 !tx_start) // RULE_14
		else $error("transmit while idle");
	a_low_first: assert property (go && phase_reg == PH_NONE |-> (ready & ((14'h1 << go_ch) - 14'h1)) == 14'h0) // RULE_23
		else $error("higher numbered channel chosen first");
endmodule

// File: bench/vtrc_engine_model.sv
// frame engine stand-in: answers each launch after a set delay
// assumes tx_start and tx_req follow the core's launch contract
`timescale 1ns/10ps
module vtrc_engine_model
	import vtrc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tx_start,
	input wire vtrc_req_s tx_req,
	input wire logic [3:0] cfg_delay, // answer delay, at least 1
	input wire logic [13:0] cfg_fail, // channels whose attempts fail
	input wire vtrc_result_s cfg_res, // outcome for failing channels
	output logic att_done,
	output vtrc_result_s att_result
);
	// =====================================================================
	// attempt timer
	logic [3:0] cnt_reg; // cycles left in attempt
	logic busy_reg; // attempt outstanding
	// one attempt at a time, outcome only valid with att_done
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			att_done <= 1'b0;
			att_result <= '0;
		end else begin
			att_done <= 1'b0;
			att_result <= ~att_result; // junk between answers
			if (tx_start) begin
				busy_reg <= 1'b1;
				cnt_reg <= cfg_delay;
			end else if (busy_reg && cnt_reg <= 4'h1) begin
				busy_reg <= 1'b0;
				att_done <= 1'b1;
				att_result <= cfg_fail[tx_req.chan] ? cfg_res : '0;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the transmit retry and mode control core
// assumes the engine model stands in for the frame engine
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top import vtrc_pkg::*;;
	// =====================================================================
	// signals
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [13:0] chan_producer = 14'h3fff;
	logic tx_start;
	vtrc_req_s tx_req;
	logic att_done;
	vtrc_result_s att_result;
	logic txd_oe_n;
	logic osc_run;
	logic buffered_clock_output;
	logic [3:0] cfg_delay = 4'h2;
	logic [13:0] cfg_fail = 14'h0000;
	vtrc_result_s cfg_res = '0;
	vtrc_req_s req_q[$]; // launched attempts
	int num_errors = 0;
	int n_checks = 0;
	int seed = 33;
	int ord[4] = '{8, 5, 8, 8}; // detour order
	vtrc_core vtrc_core_i (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chan_producer(chan_producer), .tx_start(tx_start),
		.tx_req(tx_req), .att_done(att_done), .att_result(att_result), .txd_oe_n(txd_oe_n), .osc_run(osc_run),
		.buffered_clock_output(buffered_clock_output));
	vtrc_engine_model vtrc_engine_model_i (.ref_clk(ref_clk), .rst(rst), .tx_start(tx_start), .tx_req(tx_req),
		.cfg_delay(cfg_delay), .cfg_fail(cfg_fail), .cfg_res(cfg_res), .att_done(att_done),
		.att_result(att_result));
	always #5 ref_clk = ~ref_clk;
	// log every launch
	always @(posedge ref_clk) begin
		if (tx_start === 1'b1) begin
			req_q.push_back(tx_req);
		end
	end
	// =====================================================================
	// helpers
	function automatic logic [7:0] len_a(input int c);
		return 8'h43 + 8'(4 * c);
	endfunction
	function automatic logic [7:0] ptr_a(input int c);
		return 8'h42 + 8'(4 * c);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
	endtask
	// enable a channel with a fresh log
	task automatic go(input int c, input logic [7:0] d);
		req_q.delete();
		wr(len_a(c), d);
	endtask
	task automatic wait_done(input int c);
		for (int i = 0; i < 300; i++) begin
			rd(len_a(c));
			if (reg_rdata[1] === 1'b1) break;
		end
		`CHK("tx_flag", 1'b1, reg_rdata[1])
	endtask
	task automatic wait_n(input int n);
		for (int i = 0; i < 300 && req_q.size() < n; i++) @(negedge ref_clk);
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#300000;
		num_errors++;
		give_verdict();
	end
	// =====================================================================
	// main sequence
	initial begin
		int c;
		logic [6:0] p;
		logic [4:0] l;
		logic [3:0] n;
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		`CHK("txd_reset", 1'b1, txd_oe_n)
		`CHK("osc_reset", 1'b1, osc_run)
		`CHK("buffered_clock_output_reset", 1'b1, buffered_clock_output)
		rd(8'h04);
		`CHK("idle_reset", 1'b1, reg_rdata[0])
		rd(8'h03);
		`CHK("cmd_reset", 8'h02, reg_rdata)
		rd(len_a(0));
		`CHK("len_reset", 8'h03, reg_rdata)
		wr(8'h03, 8'h01);
		repeat (3) @(negedge ref_clk);
		rd(8'h04);
		`CHK("idle_off", 1'b0, reg_rdata[0])
		`CHK("txd_on", 1'b0, txd_oe_n)
		// random successful sends
		for (int i = 0; i < 6; i++) begin
			c = $unsigned($random(seed)) % 14;
			p = 7'($random(seed));
			l = 5'($random(seed)) | 5'h01;
			cfg_delay = 4'($random(seed)) | 4'h1;
			wr(ptr_a(c), {1'b0, p});
			go(c, {l, 3'b000});
			wait_done(c);
			`CHK("req_chan", 4'(c), req_q[0].chan)
			`CHK("req_ptr", p, req_q[0].ptr)
			`CHK("req_len", l, req_q[0].len)
		end
		// linked channel 6 shares the area of channel 2
		wr(ptr_a(2), 8'h35);
		wr(len_a(2), 8'h3a);
		wr(ptr_a(6), 8'h02);
		go(6, 8'h00);
		wait_done(6);
		`CHK("link_chan", 4'h6, req_q[0].chan)
		`CHK("link_ptr", 7'h35, req_q[0].ptr)
		`CHK("link_len", 5'h07, req_q[0].len)
		// failing sends, each cause, several retry limits
		cfg_fail = 14'h3fff;
		cfg_delay = 4'hf;
		for (int k = 0; k < 4; k++) begin
			c = $unsigned($random(seed)) % 14;
			n = (k < 3) ? 4'(k) : 4'($random(seed));
			cfg_res = vtrc_result_s'(4'h4 >> (k % 3));
			wr(8'h01, {4'h0, n});
			go(c, 8'h10);
			if (n > 0) begin
				wait_n(2);
				rd(8'h05);
				`CHK("progress", {4'h1, 4'(c)}, reg_rdata)
			end
			wait_done(c);
			`CHK("attempts", n + 1, req_q.size())
			rd(8'h09);
			`CHK("te_flag", 1'b1, reg_rdata[0])
			rd(8'h07);
			`CHK("cause", 1'b1, reg_rdata[k % 3])
			wr(8'h09, 8'h01);
		end
		// contention never uses up retries
		wr(8'h01, 8'h00);
		cfg_res = vtrc_result_s'(4'h8);
		go(12, 8'h08);
		wait_n(6);
		cfg_fail = 14'h0000;
		wait_done(12);
		`CHK("contention", 1'b1, req_q.size() > 5)
		rd(8'h09);
		`CHK("no_te", 1'b0, reg_rdata[0])
		// channel 4 not a producer
		chan_producer = 14'h3fef;
		go(4, 8'h08);
		repeat (40) @(negedge ref_clk);
		`CHK("non_producer", 0, req_q.size())
		chan_producer = 14'h3fff;
		wait_done(4);
		// priority between two ready channels
		wr(8'h03, 8'h02);
		go(9, 8'h08);
		wr(len_a(3), 8'h08);
		wr(8'h03, 8'h01);
		wait_done(9);
		`CHK("first", 4'h3, req_q[0].chan)
		`CHK("second", 4'h9, req_q[1].chan)
		// abort before any attempt, then in mid-retry
		go(7, 8'h1c);
		repeat (4) @(negedge ref_clk);
		rd(len_a(7));
		`CHK("abort_idle", 1'b1, reg_rdata[1])
		`CHK("abort_none", 0, req_q.size())
		wr(8'h01, 8'h0f);
		cfg_fail = 14'h3fff;
		cfg_res = vtrc_result_s'(4'h2);
		go(11, 8'h18);
		wait_n(2);
		wr(len_a(11), 8'h1c);
		wait_done(11);
		`CHK("abort_run", 1'b1, req_q.size() < 5)
		wr(8'h09, 8'h01);
		// rearbitrate with idle requested at once
		wr(8'h01, 8'h01);
		cfg_fail = 14'h0100;
		go(8, 8'h20);
		wait_n(1);
		wr(len_a(5), 8'h10);
		wr(8'h03, 8'h0a);
		wait_done(8);
		for (int i = 0; i < 4; i++) `CHK("rearb_order", 4'(ord[i]), req_q[i].chan)
		`CHK("rearb_count", 4, req_q.size())
		rd(8'h04);
		`CHK("idle_late", 1'b1, reg_rdata[0])
		`CHK("txd_idle", 1'b1, txd_oe_n)
		// sleep blocks access until reset
		rd(8'h20);
		`CHK("unmapped", 8'h00, reg_rdata)
		wr(8'h03, 8'h05);
		repeat (3) @(negedge ref_clk);
		`CHK("osc_sleep", 1'b0, osc_run)
		`CHK("buffered_clock_output_sleep", 1'b0, buffered_clock_output)
		rd(8'h03);
		`CHK("sleep_read", 8'h00, reg_rdata)
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		`CHK("osc_wake", 1'b1, osc_run)
		rd(8'h04);
		`CHK("idle_wake", 1'b1, reg_rdata[0])
		give_verdict();
	end
endmodule
